/* logic/spc_params.svh */
// Constants of the parallel-port clocking block: register offsets,
// field positions, reset values and timing counts.
// Assumes inclusion by bare name from the design files.
`ifndef SPC_PARAMS_SVH
`define SPC_PARAMS_SVH

// Register byte offsets on the APB slave
`define SPC_CTRL_ADDR      12'h000
`define SPC_RECENTER_ADDR  12'h004
`define SPC_STATUS_ADDR    12'h008

// Control register fields
`define SPC_CTRL_TXSEL     0
`define SPC_CTRL_TXRATE    1
`define SPC_CTRL_REFHALF   2
`define SPC_CTRL_RXRATE    3
`define SPC_CTRL_RXBIST_LO 4
`define SPC_CTRL_RXBIST_HI 5
`define SPC_CTRL_TXBIST    6
`define SPC_CTRL_WIDTH     7
`define SPC_CTRL_RESET     7'h00

// Recenter register: writing 0 in bit 0 re-initialises the buffer
`define SPC_RECENTER_BIT   0

// Status register fields
`define SPC_STAT_ERR       0
`define SPC_STAT_STATE_LO  1
`define SPC_STAT_STATE_HI  2
`define SPC_STAT_FILL_LO   4

// Receive self-test mode that routes status to the outputs
`define SPC_RXBIST_ACTIVE  2'h2

// Timing counts
`define SPC_BIST_LENGTH    511
`define SPC_PAB_DEPTH      8
`define SPC_RX_CHAR_CYC    4

`endif

/* logic/spc_pkg.sv */
// Types shared by the parallel-port clocking block.
// Assumes nothing beyond a SystemVerilog compiler.
package spc_pkg;

	// Phase-align buffer condition
	typedef enum logic [1:0]
	{
		SPC_PAB_UNINIT,
		SPC_PAB_FILL,
		SPC_PAB_RUN,
		SPC_PAB_FAULT
	} spc_pab_state_t;

endpackage : spc_pkg

/* logic/spc_sync.sv */
// Two-flop synchroniser for levels from outside the clock domain.
// Assumes the input is a level or a clock well below clk/2.
`timescale 1ns/1ps
`default_nettype none

module spc_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic [W-1:0] din,
	output var  logic [W-1:0] dout
);

	logic [W-1:0] stage1;

	// First stage feeds only the second
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			stage1 <= '0;
			dout   <= '0;
		end
		else
		begin
			stage1 <= din;
			dout   <= stage1;
		end
	end

endmodule : spc_sync

`default_nettype wire

/* logic/spc_rx_port.sv */
// Receive parallel output port: interface clock pair and data timing,
// plus self-test status routing.
// Assumes rx_char is steady from same-domain receive logic.
`timescale 1ns/1ps
`default_nettype none
`include "spc_params.svh"

module spc_rx_port #(
	parameter int CHAR_CYC = `SPC_RX_CHAR_CYC
) (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       rx_rate_select,
	input  wire logic [1:0] rx_self_test_mode,
	input  wire logic [9:0] rx_char,
	input  wire logic [2:0] rx_bist_state,
	output var  logic       clk_true,
	output var  logic       clk_comp,
	output var  logic [9:0] data,
	output var  logic       bist_status
);

	logic [7:0] cnt;
	wire        char_end  = (cnt == 8'(CHAR_CYC - 1));
	wire        mid_char  = (cnt == 8'(CHAR_CYC / 2 - 1));
	wire        bist_on   = (rx_self_test_mode == `SPC_RXBIST_ACTIVE);
	wire  [9:0] next_data = bist_on ? {8'h00, rx_bist_state[1:0]} : rx_char;
	wire        next_ck   = rx_rate_select ? ~clk_true : 1'b1; // Half: toggle

	// Character-period counter, runs continuously
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			cnt <= 8'h00;
		end
		else if (char_end)
		begin
			cnt <= 8'h00;
		end
		else
			cnt <= cnt + 8'h01;
	end

	// Clock pair and data change at character starts; at full rate the clock also falls mid-character
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			clk_true    <= 1'b0;
			clk_comp    <= 1'b1;
			data        <= 10'h000;
			bist_status <= 1'b0;
		end
		else if (char_end)
		begin
			clk_true    <= next_ck;
			clk_comp    <= ~next_ck;
			data        <= next_data;
			bist_status <= bist_on & rx_bist_state[2];
		end
		else if (mid_char && !rx_rate_select)
		begin
			clk_true <= 1'b0;
			clk_comp <= 1'b1;
		end
	end

endmodule : spc_rx_port

`default_nettype wire

/* logic/spc_top.sv */
// Parallel-port clocking of one serializer / deserializer channel:
// APB control, transmit input capture and phase-align buffer,
// transmit clock output and receive output port.
// Assumes reference_clock and tx_input_clock are slow pins sampled
// by clk; rx_char and rx_bist_state come from same-domain logic.
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "spc_params.svh"

module spc_top
	import spc_pkg::*;
#(
	parameter int PAB_DEPTH   = `SPC_PAB_DEPTH,
	parameter int BIST_LENGTH = `SPC_BIST_LENGTH,
	parameter int RX_CHAR_CYC = `SPC_RX_CHAR_CYC
) (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic        reference_clock,
	input  wire logic        tx_input_clock,
	input  wire logic [9:0]  tx_parallel_data,
	output var  logic        tx_path_error,
	output var  logic        tx_clock_out,
	output var  logic [9:0]  tx_char,
	output var  logic        tx_char_valid,
	input  wire logic [9:0]  rx_char,
	input  wire logic [2:0]  rx_bist_state,
	output var  logic        rx_interface_clock_p,
	output var  logic        rx_interface_clock_n,
	output var  logic [9:0]  rx_parallel_data,
	output var  logic        self_test_status_out
);

	import spc_pkg::*;

	localparam int AW = $clog2(PAB_DEPTH);

	// ------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------
	logic [`SPC_CTRL_WIDTH-1:0] ctrl;
	logic                       recenter_req;
	spc_pab_state_t             pab_state;
	logic [AW:0]                pab_fill;

	wire setup_rd   = psel & ~penable & ~pwrite;
	wire setup_any  = psel & ~penable;
	wire access_wr  = psel & penable & pwrite;
	wire hit_ctrl   = (paddr == `SPC_CTRL_ADDR);
	wire hit_recent = (paddr == `SPC_RECENTER_ADDR);
	wire hit_status = (paddr == `SPC_STATUS_ADDR);
	wire hit_any    = hit_ctrl | hit_recent | hit_status;

	wire tx_sel     = ctrl[`SPC_CTRL_TXSEL];
	wire tx_rate    = ctrl[`SPC_CTRL_TXRATE];
	wire ref_half   = ctrl[`SPC_CTRL_REFHALF];
	wire rx_rate    = ctrl[`SPC_CTRL_RXRATE];
	wire [1:0] rx_bist_mode = ctrl[`SPC_CTRL_RXBIST_HI:`SPC_CTRL_RXBIST_LO];
	wire tx_bist_en = ctrl[`SPC_CTRL_TXBIST];

	wire [31:0] status_word = {
		{(32 - `SPC_STAT_FILL_LO - AW - 1){1'b0}},
		pab_fill,
		1'b0,
		pab_state,
		tx_path_error
	};

	wire [31:0] rd_mux =
		hit_ctrl   ? {{(32 - `SPC_CTRL_WIDTH){1'b0}}, ctrl} :
		hit_recent ? 32'h00000001 :
		hit_status ? status_word : 32'h00000000;

	wire recenter_wr = access_wr & hit_recent &
		~pwdata[`SPC_RECENTER_BIT];

	// Read data and error prepared in the setup cycle
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
			pready  <= 1'b0;
		end
		else
		begin
			pready <= 1'b1;
			if (setup_rd)
				prdata <= rd_mux;
			if (setup_any)
				pslverr <= ~hit_any;
		end
	end

	// Control writes and the recenter request
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			ctrl         <= `SPC_CTRL_RESET;
			recenter_req <= 1'b0;
		end
		else
		begin
			if (access_wr && hit_ctrl)
				ctrl <= pwdata[`SPC_CTRL_WIDTH-1:0];
			recenter_req <= recenter_wr;
		end
	end

	// ------------------------------------------------------------
	// Pin sampling and edge finding
	// ------------------------------------------------------------
	logic       ref_s;
	logic       txck_s;
	logic       ref_d;
	logic       txck_d;
	logic [9:0] txd_s;

	spc_sync #(.W(12)) u_sync (
		.clk    (clk),
		.resetn (resetn),
		.din    ({reference_clock, tx_input_clock, tx_parallel_data}),
		.dout   ({ref_s, txck_s, txd_s})
	);

	// Previous sampled clock levels
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			ref_d  <= 1'b0;
			txck_d <= 1'b0;
		end
		else
		begin
			ref_d  <= ref_s;
			txck_d <= txck_s;
		end
	end

	wire ref_rise  = ref_s & ~ref_d;
	wire ref_fall  = ~ref_s & ref_d;
	wire txck_rise = txck_s & ~txck_d;

	// Character clock: reference edges, both when half-rate or doubled
	wire char_tick = ref_rise | (ref_fall & (ref_half | tx_rate));

	// Capture clock chosen by the select latch
	wire cap_tick = tx_sel ? char_tick : txck_rise;

	// ------------------------------------------------------------
	// Phase-align buffer
	// ------------------------------------------------------------
	logic [9:0]    pab_mem [PAB_DEPTH];
	logic [AW-1:0] wptr;
	logic [AW-1:0] rptr;

	wire pab_full  = (pab_fill == (AW+1)'(PAB_DEPTH));
	wire pab_empty = (pab_fill == '0);
	wire pab_run   = (pab_state == SPC_PAB_RUN);
	wire pab_wr    = cap_tick & ~pab_full &
		((pab_state == SPC_PAB_FILL) | pab_run);
	wire pab_rd    = char_tick & pab_run & ~pab_empty;
	wire slip      = pab_run &
		((cap_tick & pab_full) | (char_tick & pab_empty));
	wire half_full = (pab_fill >= (AW+1)'(PAB_DEPTH / 2));

	// Storage, written at the write index
	always_ff @(posedge clk)
	begin
		if (pab_wr)
			pab_mem[wptr] <= txd_s;
	end

	// Pointers and fill level
	always_ff @(posedge clk)
	begin
		if (!resetn || recenter_req)
		begin
			wptr     <= '0;
			rptr     <= '0;
			pab_fill <= '0;
		end
		else
		begin
			if (pab_wr)
				wptr <= wptr + AW'(1);
			if (pab_rd)
				rptr <= rptr + AW'(1);
			if (pab_wr && !pab_rd)
				pab_fill <= pab_fill + (AW+1)'(1);
			else if (pab_rd && !pab_wr)
				pab_fill <= pab_fill - (AW+1)'(1);
		end
	end

	// Buffer condition: filled to half before characters flow
	spc_pab_state_t next_state;
	always_comb
	begin
		next_state = pab_state;
		case (pab_state)
			SPC_PAB_UNINIT: next_state = SPC_PAB_UNINIT;
			SPC_PAB_FILL:
				if (half_full)
					next_state = SPC_PAB_RUN;
			SPC_PAB_RUN:
				if (slip)
					next_state = SPC_PAB_FAULT;
			SPC_PAB_FAULT:  next_state = SPC_PAB_FAULT;
			default:        next_state = SPC_PAB_UNINIT;
		endcase
		if (recenter_req && !slip)              // Slip in same cycle wins
			next_state = SPC_PAB_FILL;
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
			pab_state <= SPC_PAB_UNINIT;
		else
			pab_state <= next_state;
	end

	// Characters toward the serializer
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			tx_char       <= 10'h000;
			tx_char_valid <= 1'b0;
		end
		else
		begin
			tx_char_valid <= pab_rd;
			if (pab_rd)
				tx_char <= pab_mem[rptr];
		end
	end

	// ------------------------------------------------------------
	// Transmit self-test progress and error flag
	// ------------------------------------------------------------
	logic [9:0] bist_cnt;
	wire        bist_wrap = (bist_cnt == 10'(BIST_LENGTH - 1));

	// Pass counter over the generator sequence
	always_ff @(posedge clk)
	begin
		if (!resetn || !tx_bist_en)
			bist_cnt <= 10'h000;
		else if (char_tick)
			bist_cnt <= bist_wrap ? 10'h000 : bist_cnt + 10'h001;
	end

	wire next_err = tx_bist_en ? bist_wrap : ~pab_run;

	// Flag moves only on character-clock edges
	always_ff @(posedge clk)
	begin
		if (!resetn)
			tx_path_error <= 1'b1;
		else if (char_tick)
			tx_path_error <= next_err;
	end

	// ------------------------------------------------------------
	// Transmit clock output
	// ------------------------------------------------------------
	logic [7:0] ph_cnt;
	logic [7:0] ref_period;

	wire [7:0] q1 = {2'b00, ref_period[7:2]};
	wire [7:0] q2 = {1'b0, ref_period[7:1]};
	wire [7:0] q3 = q1 + q2;
	wire next_txo = tx_rate ?
		((ph_cnt < q1) | ((ph_cnt >= q2) & (ph_cnt < q3))) :
		(ph_cnt < q2);

	// Phase within the reference period and the period length
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			ph_cnt       <= 8'h00;
			ref_period   <= 8'h00;
			tx_clock_out <= 1'b0;
		end
		else
		begin
			if (ref_rise)
			begin
				ph_cnt     <= 8'h00;
				ref_period <= ph_cnt + 8'h01;
			end
			else if (ph_cnt != 8'hFF)
				ph_cnt <= ph_cnt + 8'h01;
			tx_clock_out <= next_txo;
		end
	end

	// ------------------------------------------------------------
	// Receive output port
	// ------------------------------------------------------------
	spc_rx_port #(.CHAR_CYC(RX_CHAR_CYC)) u_rx (
		.clk               (clk),
		.resetn            (resetn),
		.rx_rate_select    (rx_rate),
		.rx_self_test_mode (rx_bist_mode),
		.rx_char           (rx_char),
		.rx_bist_state     (rx_bist_state),
		.clk_true          (rx_interface_clock_p),
		.clk_comp          (rx_interface_clock_n),
		.data              (rx_parallel_data),
		.bist_status       (self_test_status_out)
	);

endmodule : spc_top

`default_nettype wire

/* testbench/spc_asserts.sv */
// Port checker for spc_top.
// Assumes binding to spc_top; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module spc_asserts (
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic [11:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        tx_path_error,
	input wire logic        tx_char_valid,
	input wire logic        rx_interface_clock_p,
	input wire logic        rx_interface_clock_n,
	input wire logic [9:0]  rx_parallel_data
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// Access decode and recenter strobe
	wire logic acc = psel && penable;
	wire logic bad = !(paddr inside {12'h000, 12'h004, 12'h008});
	wire logic rc = acc && pwrite && paddr == 12'h004 && !pwdata[0];
	logic [7:0] since_rc;
	logic       bist_on;
	// Transmit self-test enable as last written to control
	always_ff @(posedge clk)
	begin
		if (!resetn)
			bist_on <= 1'b0;
		else if (acc && pwrite && paddr == 12'h000)
			bist_on <= pwdata[6];
	end
	// Cycles since the last recenter write, saturating
	always_ff @(posedge clk)
	begin
		if (!resetn || rc)
			since_rc <= 8'h00;
		else if (since_rc != 8'hFF)
			since_rc <= since_rc + 8'h01;
	end
	rst_vals_a: assert property (disable iff (1'b0)
		!resetn |=> tx_path_error && !pready && rx_interface_clock_n)
		else $error("reset values wrong");
	rdy_up_a: assert property ($past(resetn) |-> pready)
		else $error("pready low after reset");
	bad_addr_a: assert property (acc && bad |-> pslverr && prdata == 0)
		else $error("unmapped access answered");
	rc_read_a: assert property (
		acc && !pwrite && paddr == 12'h004 |-> prdata == 32'h1)
		else $error("recenter read not one");
	err_hold_a: assert property (
		$fell(tx_path_error) && !bist_on |-> since_rc < 8'hC0)
		else $error("error cleared without recenter");
	vld_pulse_a: assert property (tx_char_valid |=> !tx_char_valid)
		else $error("valid longer than one cycle");
	rx_comp_a: assert property (
		rx_interface_clock_p != rx_interface_clock_n)
		else $error("receive clocks not complementary");
	rx_data_a: assert property (
		!$stable(rx_parallel_data) |-> !$stable(rx_interface_clock_p))
		else $error("receive data moved off clock edge");
	rx_run_a: assert property (
		!$stable(rx_interface_clock_p) |-> ##[1:4] !$stable(rx_interface_clock_p))
		else $error("receive clock stopped");
	// Main scenarios
	rc_c: cover property (rc);
	fell_c: cover property ($fell(tx_path_error));
	bad_c: cover property (acc && bad);
endmodule : spc_asserts
`default_nettype wire

/* testbench/spc_host_model.sv */
// Host logic model: transmit input clock and counting characters.
// Assumes clk at eight times the character rate.
`timescale 1ns/1ps
`default_nettype none
module spc_host_model (
	input  wire logic       clk,
	input  wire logic       run,
	output wire logic       tx_input_clock,
	output wire logic [9:0] tx_parallel_data
);
	logic [2:0] phase = 3'h0;
	logic [9:0] ch    = 10'h000;
	// Clock stands low while stopped; period fixed to the reference
	assign tx_input_clock = run && phase < 3'h4;
	assign tx_parallel_data = ch;
	// New character at the falling edge, far from capture
	always @(posedge clk)
	begin
		if (run)
			phase <= phase + 3'h1;
		if (run && phase == 3'h3)
			ch <= ch + 10'h001;
	end
endmodule : spc_host_model
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for spc_top over APB with a host model.
// Assumes spc_asserts and spc_host_model compiled before.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, run = 1'b0, refclk = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, e, txclk, err, tco, vld, rxp, rxn, sts;
	logic [9:0] txd, txc, rxd, rx_char = 10'h000, c0, c1;
	logic [2:0] rx_bist_state = 3'h0, rcnt = 3'h0;
	int n_mismatch = 0, total_checks = 0, cyc = 0, k;
	spc_top dut (.clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .reference_clock(refclk),
		.tx_input_clock(txclk), .tx_parallel_data(txd), .tx_path_error(err),
		.tx_clock_out(tco), .tx_char(txc), .tx_char_valid(vld),
		.rx_char(rx_char), .rx_bist_state(rx_bist_state),
		.rx_interface_clock_p(rxp), .rx_interface_clock_n(rxn),
		.rx_parallel_data(rxd), .self_test_status_out(sts));
	spc_host_model host (.clk(clk), .run(run), .tx_input_clock(txclk),
		.tx_parallel_data(txd));
	// Clock, reference clock and timeout
	always #20 clk = ~clk;
	always @(posedge clk)
	begin
		rcnt <= rcnt + 3'h1;
		refclk <= rcnt[2];
		cyc++;
		if (cyc == 20000)
		begin
			n_mismatch++;
			conclude();
		end
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		total_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask : chk
	// One APB transfer, held until pready
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic rdc(input logic [11:0] a, input logic [31:0] x,
		input string m);
		apb(1'b0, a, 32'h0);
		chk(q, x, m);
	endtask : rdc
	// Wait for the error flag to reach a level, bounded
	task automatic wait_err(input logic lv, input string m);
		k = 0;
		while (err !== lv && k < 400)
		begin
			k++;
			@(negedge clk);
		end
		chk({31'h0, err}, {31'h0, lv}, m);
		@(posedge clk);
	endtask : wait_err
	task automatic next_char(output logic [9:0] c);
		k = 0;
		@(negedge clk);
		while (vld !== 1'b1 && k < 100)
		begin
			k++;
			@(negedge clk);
		end
		c = txc;
	endtask : next_char
	initial
	begin
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		rdc(12'h000, 32'h0, "ctrl reset value");
		apb(1'b1, 12'h000, 32'h3F);
		rdc(12'h000, 32'h3F, "ctrl readback");
		rdc(12'h004, 32'h1, "recenter read");
		rdc(12'h00C, 32'h0, "unmapped read");
		chk({31'h0, e}, 32'h1, "unmapped error");
		rdc(12'h008, 32'h1, "status after reset");
		$display("test registers done");
		apb(1'b1, 12'h000, 32'h0);
		run <= 1'b1;
		apb(1'b1, 12'h004, 32'h0);
		wait_err(1'b0, "error not cleared");
		apb(1'b0, 12'h008, 32'h0);
		chk({28'h0, q[3:0]}, 32'h4, "status running");
		chk({31'h0, q[7:4] inside {[3:5]}}, 32'h1, "fill level");
		next_char(c0);
		repeat (3)
		begin
			next_char(c1);
			chk(c1, c0 + 10'h001, "character order");
			c0 = c1;
		end
		$display("test capture done");
		@(posedge clk);
		run <= 1'b0;
		wait_err(1'b1, "slip not flagged");
		run <= 1'b1;
		repeat (200) @(posedge clk);
		chk({31'h0, err}, 32'h1, "error not sticky");
		apb(1'b1, 12'h004, 32'h0);
		wait_err(1'b0, "recenter failed");
		$display("test slip done");
		for (int r = 0; r < 2; r++)
		begin
			apb(1'b1, 12'h000, r << 1);
			k = 0;
			@(negedge clk);
			c0 = {9'h0, tco};
			repeat (320)
			begin
				@(negedge clk);
				k += (tco === 1'b1 && c0 == 0);
				c0 = {9'h0, tco};
			end
			chk(k >= 39 * (r + 1) && k <= 41 * (r + 1), 1, "tx clock rate");
		end
		apb(1'b1, 12'h000, 32'h1);
		apb(1'b1, 12'h004, 32'h0);
		wait_err(1'b0, "reference capture");
		$display("test clocks done");
		apb(1'b1, 12'h000, 32'h20);
		rx_bist_state <= 3'h5;
		rx_char <= 10'h3FF;
		repeat (12) @(posedge clk);
		chk({sts, rxd[1:0]}, 3'h5, "self-test routing");
		apb(1'b1, 12'h000, 32'h0);
		repeat (12) @(posedge clk);
		chk({sts, rxd}, 11'h3FF, "full rate data");
		apb(1'b1, 12'h000, 32'h8);
		rx_char <= 10'h155;
		repeat (12) @(posedge clk);
		chk({22'h0, rxd}, 32'h155, "half rate data");
		$display("test receive done");
		// Transmit self-test: one-character error pulse per pass
		apb(1'b1, 12'h000, 32'h40);
		while (err !== 1'b1)
			@(negedge clk);
		k = 0;
		while (err === 1'b1)
		begin
			k++;
			@(negedge clk);
		end
		chk(k, 8, "self-test pulse width");
		while (err !== 1'b1)
		begin
			k++;
			@(negedge clk);
		end
		chk(k, 4088, "self-test pass length");
		$display("test self-test done");
		conclude();
	end
endmodule : testbench
bind spc_top spc_asserts chk_i (.clk(clk), .resetn(resetn), .paddr(paddr),
	.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.tx_path_error(tx_path_error), .tx_char_valid(tx_char_valid),
	.rx_interface_clock_p(rx_interface_clock_p),
	.rx_interface_clock_n(rx_interface_clock_n),
	.rx_parallel_data(rx_parallel_data));
`default_nettype wire
